// file: logic/quadrature_position_counter.sv
// top: three encoder channels behind an Avalon-MM slave
// assumes rst synchronous to clk; receiver fault lines are async pins
// Notes on behaviour
// - three independent channels, each with own count and settings
// - count changes only on rising A edges; B sampled there
// - clockwise adds one, counterclockwise subtracts one
// - count is signed 32-bit, wraps silently
// - host reads a coherent untorn 32-bit count any time
// - host may clear a channel's count to zero any time
// - index input ignored, never touches the count
// - no encoder fault input; fault only from receiver monitor
// - each channel has own two-bit signal format
// - activity indicator asserted while edges are seen
// - fault indicator follows that channel's receiver fault
// - termination indicator set while RS-422 format selected
`timescale 1ns/1ps
module quadrature_position_counter
  import qpc_pkg::*;
#(
  parameter bit          CW_WHEN_B_LOW = 1'b1,
  parameter int unsigned ACT_CYCLES    = ACTIVITY_CYC
)(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // avalon-mm slave
  input  wire logic [ADDR_WIDTH-1:0]  address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic [31:0]                 readdata,
  output logic                        waitrequest,
  output logic [1:0]                  response,
  // encoder pins
  input  wire enc_pins_t [NUM_CHANNELS-1:0] enc,
  input  wire logic [NUM_CHANNELS-1:0]      rx_fault,
  // receiver control and indicators
  output signal_format_t [NUM_CHANNELS-1:0] select_signal_format,
  output chan_status_t [NUM_CHANNELS-1:0]   status,
  output logic                              irq
);

  initial
  begin
    if (ACT_CYCLES < 1 || ACT_CYCLES > 24'hff_ffff)
      $error("quadrature_position_counter: bad ACT_CYCLES");
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [NUM_CHANNELS-1:0]  clr_q, clr_d;
  logic [POS_WIDTH-1:0]     pos [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0]  act;

  for (genvar i = 0; i < NUM_CHANNELS; i++)
  begin : g_ch
    quad_channel #(
      .CW_WHEN_B_LOW (CW_WHEN_B_LOW),
      .ACT_CYCLES    (ACT_CYCLES)
    ) u_ch (
      .clk      (clk),
      .rst      (rst),
      .pins     (enc[i]),
      .clear    (clr_q[i]),
      .position (pos[i]),
      .active   (act[i])
    );
  end

  // ----------------------------------------------------------------
  // fault synchroniser
  // ----------------------------------------------------------------
  logic [NUM_CHANNELS-1:0] flt_s1_q, flt_s1_d, flt_s2_q, flt_s2_d;

  always_comb
  begin
    flt_s1_d = rx_fault;
    flt_s2_d = flt_s1_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flt_s1_q <= 3'h0;
      flt_s2_q <= 3'h0;
    end
    else
    begin
      flt_s1_q <= flt_s1_d;
      flt_s2_q <= flt_s2_d;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [5:0]              fmt_q, fmt_d;
  logic [7:0]              ist_q, ist_d;
  logic [7:0]              imk_q, imk_d;
  logic [NUM_CHANNELS-1:0] flt_prev_q, flt_prev_d;
  logic [NUM_CHANNELS-1:0] act_prev_q, act_prev_d;
  logic [31:0]             rd_q, rd_d;
  logic [1:0]              rsp_q, rsp_d;
  logic                    ack_q, ack_d;
  logic [7:0]              ev;
  logic [11:0]             stat_word;
  logic                    req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++)
      if (be[k])
        r[k*8 +: 8] = nw[k*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic is_rs422(input logic [5:0] f,
                                    input int         ch);
    return f[ch*FMT_BITS +: FMT_BITS] == fmt_rs422;
  endfunction : is_rs422

  always_comb
  begin
    req        = (read | write) & ~ack_q;
    ack_d      = req;
    flt_prev_d = flt_s2_q;
    act_prev_d = act;
    ev         = 8'h00;
    ev[STAT_ACT_LSB +: 3] = act & ~act_prev_q;
    ev[IRQ_FLT_LSB  +: 3] = flt_s2_q & ~flt_prev_q;
    stat_word  = 12'h000;
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      stat_word[STAT_ACT_LSB + i]  = act[i];
      stat_word[STAT_FLT_LSB + i]  = flt_s2_q[i];
      stat_word[STAT_TERM_LSB + i] = is_rs422(fmt_q, i);
    end
    fmt_d = fmt_q;
    imk_d = imk_q;
    clr_d = 3'h0;
    ist_d = ist_q;
    rd_d  = 32'h0000_0000;
    rsp_d = 2'h0;
    if (req && write)
    begin
      case (address)
        OFS_CLEAR:  clr_d = writedata[2:0];
        OFS_FORMAT: fmt_d = 6'(merge({26'h0, fmt_q}, writedata,
                                     byteenable));
        OFS_IRQ_ST: if (byteenable[0])
                      ist_d = ist_q & ~writedata[7:0];
        OFS_IRQ_MK: imk_d = 8'(merge({24'h0, imk_q}, writedata,
                                     byteenable));
        OFS_POS0, OFS_POS1, OFS_POS2, OFS_STATUS: ;
        default:    rsp_d = 2'h2;
      endcase
    end
    ist_d = ist_d | ev; // set beats clear
    if (req && read)
    begin
      case (address)
        OFS_POS0:   rd_d = pos[0];
        OFS_POS1:   rd_d = pos[1];
        OFS_POS2:   rd_d = pos[2];
        OFS_FORMAT: rd_d = {26'h0, fmt_q};
        OFS_STATUS: rd_d = {20'h0, stat_word};
        OFS_IRQ_ST: rd_d = {24'h0, ist_q};
        OFS_IRQ_MK: rd_d = {24'h0, imk_q};
        OFS_CLEAR:  rd_d = 32'h0000_0000;
        default:    rsp_d = 2'h2;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fmt_q      <= FORMAT_RESET;
      imk_q      <= 8'h00;
      ist_q      <= 8'h00;
      clr_q      <= 3'h0;
      rd_q       <= 32'h0000_0000;
      rsp_q      <= 2'h0;
      ack_q      <= 1'b0;
      flt_prev_q <= 3'h0;
      act_prev_q <= 3'h0;
    end
    else
    begin
      fmt_q      <= fmt_d;
      imk_q      <= imk_d;
      ist_q      <= ist_d;
      clr_q      <= clr_d;
      rd_q       <= rd_d;
      rsp_q      <= rsp_d;
      ack_q      <= ack_d;
      flt_prev_q <= flt_prev_d;
      act_prev_q <= act_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rd_q;
  assign response    = rsp_q;
  assign irq         = |(ist_q & imk_q);

  for (genvar i = 0; i < NUM_CHANNELS; i++)
  begin : g_out
    assign select_signal_format[i] =
      signal_format_t'(fmt_q[i*FMT_BITS +: FMT_BITS]);
    assign status[i].active = act[i];
    assign status[i].fault  = flt_s2_q[i];
    assign status[i].term   = is_rs422(fmt_q, i);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence wr_clear_s;
    write && !ack_q && address == OFS_CLEAR && writedata[0];
  endsequence

  clear_path_a: assert property (@(posedge clk) disable iff (rst)
    wr_clear_s |=> ##1 pos[0] == 32'h0)
    else $error("channel 0 not cleared");
  read_snap_a: assert property (@(posedge clk) disable iff (rst)
    (read && !ack_q && address == OFS_POS0)
      |=> readdata == $past(pos[0]))
    else $error("position read not the sampled count");
  term_rs422_a: assert property (@(posedge clk) disable iff (rst)
    status[1].term == (select_signal_format[1] == fmt_rs422))
    else $error("termination indicator wrong");
  fault_lag_a: assert property (@(posedge clk) disable iff (rst)
    $rose(flt_s2_q[0]) |=> ist_q[IRQ_FLT_LSB])
    else $error("fault rise did not set its status bit");
  fmt_own_a: assert property (@(posedge clk) disable iff (rst)
    (write && !ack_q && address == OFS_FORMAT
      && byteenable[0] && writedata[5:2] == fmt_q[5:2])
      |=> $stable(fmt_q[5:2]))
    else $error("format write disturbed another channel");
  wait_one_a: assert property (@(posedge clk) disable iff (rst)
    (read || write) && !ack_q |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");

endmodule : quadrature_position_counter

// file: logic/qpc_pkg.sv
// package for the quadrature position counter
// assumes a single 20 MHz clock domain and an Avalon-MM register bus
package qpc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS = 3;
  localparam int unsigned POS_WIDTH    = 32;
  localparam int unsigned ADDR_WIDTH   = 6;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_POS0   = 6'h00;
  localparam logic [5:0] OFS_POS1   = 6'h04;
  localparam logic [5:0] OFS_POS2   = 6'h08;
  localparam logic [5:0] OFS_CLEAR  = 6'h0c;
  localparam logic [5:0] OFS_FORMAT = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_IRQ_ST = 6'h18;
  localparam logic [5:0] OFS_IRQ_MK = 6'h1c;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned FMT_BITS      = 2;
  localparam int unsigned STAT_ACT_LSB  = 0;
  localparam int unsigned STAT_FLT_LSB  = 4;
  localparam int unsigned STAT_TERM_LSB = 8;
  localparam int unsigned IRQ_FLT_LSB   = 4;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] POS_RESET      = 32'h0000_0000;
  localparam logic [5:0]  FORMAT_RESET   = 6'h00;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned ACTIVITY_US    = 100;
  localparam int unsigned ACTIVITY_CYC   =
    (ACTIVITY_US * (CLK_HZ / 1_000_000));

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    fmt_single_ended_high_threshold = 2'h0,
    fmt_differential_high_threshold = 2'h1,
    fmt_rs422                       = 2'h2,
    fmt_ttl                         = 2'h3
  } signal_format_t;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } enc_pins_t;

  typedef struct packed {
    logic active;
    logic fault;
    logic term;
  } chan_status_t;

endpackage : qpc_pkg

// file: logic/quad_channel.sv
// one encoder channel: synchroniser, edge detect, signed counter
// assumes encoder pins are asynchronous to clk
`timescale 1ns/1ps
module quad_channel
  import qpc_pkg::*;
#(
  parameter bit          CW_WHEN_B_LOW = 1'b1,
  parameter int unsigned ACT_CYCLES    = ACTIVITY_CYC
)(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // encoder pins
  input  wire enc_pins_t            pins,
  // control
  input  wire logic                 clear,
  // state
  output logic [POS_WIDTH-1:0]      position,
  output logic                      active
);

  initial
  begin
    if (ACT_CYCLES < 1)
      $error("quad_channel: ACT_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [1:0]            a_sync_q, a_sync_d, b_sync_q, b_sync_d;
  logic                  a_prev_q, a_prev_d;
  logic                  b_prev_q, b_prev_d;
  logic [POS_WIDTH-1:0]  pos_q, pos_d;
  logic [23:0]           act_q, act_d;
  logic                  rise, cw;

  always_comb
  begin
    a_sync_d = {a_sync_q[0], pins.a};
    b_sync_d = {b_sync_q[0], pins.b};
    a_prev_d = a_sync_q[1];
    b_prev_d = b_sync_q[1];
    rise     = a_sync_q[1] & ~a_prev_q;
    // index input deliberately unused
    cw       = b_sync_q[1] ^ CW_WHEN_B_LOW;
    pos_d    = pos_q;
    if (clear)
      pos_d = POS_RESET;
    else if (rise && cw)
      pos_d = pos_q + 32'h0000_0001;
    else if (rise)
      pos_d = pos_q - 32'h0000_0001;
    act_d = act_q;
    if (rise || (b_sync_q[1] != b_prev_q))
      act_d = 24'(ACT_CYCLES);
    else if (act_q != 24'h00_0000)
      act_d = act_q - 24'h00_0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      pos_q    <= POS_RESET;
      act_q    <= 24'h00_0000;
    end
    else
    begin
      a_sync_q <= a_sync_d;
      b_sync_q <= b_sync_d;
      a_prev_q <= a_prev_d;
      b_prev_q <= b_prev_d;
      pos_q    <= pos_d;
      act_q    <= act_d;
    end
  end

  assign position = pos_q;
  assign active   = (act_q != 24'h00_0000);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  clear_wins_a: assert property (@(posedge clk) disable iff (rst)
    clear |=> pos_q == POS_RESET)
    else $error("count not zero after clear");
  step_one_a: assert property (@(posedge clk) disable iff (rst)
    (!clear && rise) |=> (pos_q == $past(pos_q) + 32'h1
      || pos_q == $past(pos_q) - 32'h1))
    else $error("count did not move by one");
  hold_still_a: assert property (@(posedge clk) disable iff (rst)
    (!clear && !rise) |=> $stable(pos_q))
    else $error("count moved without a rising edge");
  dir_cw_a: assert property (@(posedge clk) disable iff (rst)
    (!clear && rise && (b_sync_q[1] != CW_WHEN_B_LOW))
      |=> pos_q == $past(pos_q) + 32'h1)
    else $error("clockwise step wrong");

endmodule : quad_channel

// file: test/encoder_model.sv
// encoder model: quadrature a/b/z pins for every channel
// assumes tasks are called just after a rising clk edge
`timescale 1ns/1ps
module encoder_model
  import qpc_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // encoder pins
  output enc_pins_t [NUM_CHANNELS-1:0] enc
);
  initial enc = '0;

  // ----------------------------------------------------------------
  // full quadrature cycles, gap cycles between phase changes
  // ----------------------------------------------------------------
  task automatic move(input int ch, input bit cw, input int n,
                      input int gap);
    logic [1:0] ab;
    for (int s = 0; s < 4 * n; s++)
    begin
      repeat (gap) @(posedge clk);
      ab = {enc[ch].a, enc[ch].b};
      // cw: a rises while b is low
      ab = cw ? {~ab[0], ab[1]} : {ab[0], ~ab[1]};
      enc[ch].a <= ab[1];
      enc[ch].b <= ab[0];
      // index noise that must never touch the count
      enc[ch].z <= ~enc[ch].z;
    end
    repeat (gap) @(posedge clk);
  endtask : move

  // ----------------------------------------------------------------
  // b toggles while a stays low
  // ----------------------------------------------------------------
  task automatic wiggle(input int ch, input int n, input int gap);
    for (int s = 0; s < 2 * n; s++)
    begin
      repeat (gap) @(posedge clk);
      enc[ch].b <= ~enc[ch].b;
      enc[ch].z <= ~enc[ch].z;
    end
  endtask : wiggle
endmodule : encoder_model

// file: test/quadrature_position_counter_test.sv
// bench for the quadrature position counter
// assumes encoder_model as far side and an avalon-mm master here
`timescale 1ns/1ps
module quadrature_position_counter_test
  import qpc_pkg::*;
();
  localparam int          ACT = 20;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } note_t;

  logic                                clk;
  logic                                rst;
  logic [ADDR_WIDTH-1:0]               address;
  logic                                read;
  logic                                write;
  logic [31:0]                         writedata;
  logic [3:0]                          byteenable;
  logic [31:0]                         readdata;
  logic                                waitrequest;
  logic [1:0]                          response;
  enc_pins_t [NUM_CHANNELS-1:0]        enc;
  logic [NUM_CHANNELS-1:0]             rx_fault;
  signal_format_t [NUM_CHANNELS-1:0]   fmt;
  chan_status_t [NUM_CHANNELS-1:0]     status;
  logic                                irq;
  note_t                               notes[$];
  note_t                               cur;
  int                                  bad_count;
  int                                  check_count;
  int                                  n;
  int                                  c;
  logic [31:0]                         rnd;
  logic [5:0]                          f;

  quadrature_position_counter #(
    .CW_WHEN_B_LOW (1'b1),
    .ACT_CYCLES    (ACT)
  ) u_quadrature_position_counter (
    .clk                  (clk),
    .rst                  (rst),
    .address              (address),
    .read                 (read),
    .write                (write),
    .writedata            (writedata),
    .byteenable           (byteenable),
    .readdata             (readdata),
    .waitrequest          (waitrequest),
    .response             (response),
    .enc                  (enc),
    .rx_fault             (rx_fault),
    .select_signal_format (fmt),
    .status               (status),
    .irq                  (irq)
  );

  encoder_model u_encoder_model (
    .clk (clk),
    .enc (enc)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic check_word(input logic [31:0] got,
                            input logic [31:0] exp,
                            input logic [31:0] m);
    check_count++;
    if ((got & m) !== (exp & m))
    begin
      bad_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp}, 32'h1);
  endtask : check_bit

  // one bus cycle; entered just after a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] wd);
    int k;
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= wd;
    byteenable <= 4'hf;
    k = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 50)
    begin
      bad_count++;
      test_done();
    end
    else
    begin
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
    end
  endtask : bus

  task automatic expect_read(input logic [5:0] a, input logic [31:0] d,
                             input logic [31:0] m, input logic [1:0] r);
    notes.push_back('{d, m, r});
    bus(1'b0, a, 32'h0);
  endtask : expect_read

  // ----------------------------------------------------------------
  // read monitor
  // ----------------------------------------------------------------
  always @(posedge clk)
    if (!rst && read === 1'b1 && waitrequest === 1'b0)
    begin
      cur = notes.pop_front();
      check_word(readdata, cur.d, cur.m);
      check_word({30'h0, response}, {30'h0, cur.r}, 32'h3);
    end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = '0;
    rx_fault = '0;
    rnd = 32'he0e902c0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      expect_read(6'(4 * i), 32'h0, (i == 3) ? 32'h0 : ALL, 2'b00);
    expect_read(6'h20, 32'h0, ALL, 2'b10);
    bus(1'b1, 6'h24, rnd);
    fork
      u_encoder_model.move(0, 1'b1, 500, 3);
      u_encoder_model.move(2, 1'b0, 3, 5);
      u_encoder_model.wiggle(1, 9, 4);
    join
    u_encoder_model.move(0, 1'b0, 499, 3);
    expect_read(OFS_STATUS, 32'h001, 32'h777, 2'b00);
    expect_read(OFS_POS0, 32'h1, ALL, 2'b00);
    expect_read(OFS_POS1, 32'h0, ALL, 2'b00);
    expect_read(OFS_POS2, 32'hffff_fffd, ALL, 2'b00);
    repeat (ACT + 10) @(posedge clk);
    expect_read(OFS_STATUS, 32'h0, 32'h777, 2'b00);
    expect_read(OFS_IRQ_ST, 32'h7, 32'h77, 2'b00);
    bus(1'b1, OFS_IRQ_ST, 32'h77);
    expect_read(OFS_IRQ_ST, 32'h0, 32'h77, 2'b00);
    rnd = lfsr(rnd);
    n = int'(rnd[3:0]) + 1;
    u_encoder_model.move(1, 1'b1, n, 4);
    expect_read(OFS_POS1, 32'(n), ALL, 2'b00);
    bus(1'b1, OFS_CLEAR, 32'h2);
    expect_read(OFS_POS1, 32'h0, ALL, 2'b00);
    bus(1'b1, OFS_POS0, rnd);
    expect_read(OFS_POS0, 32'h1, ALL, 2'b00);
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      f = {~2'(k), rnd[1:0], 2'(k)};
      bus(1'b1, OFS_FORMAT, {26'h0, f});
      expect_read(OFS_FORMAT, {26'h0, f}, ALL, 2'b00);
      #1;
      for (int j = 0; j < 3; j++)
      begin
        check_word({30'h0, fmt[j]}, {30'h0, f[2*j+:2]}, 32'h3);
        check_bit(status[j].term, f[2*j+:2] == 2'h2);
      end
      @(posedge clk);
    end
    bus(1'b1, OFS_IRQ_MK, 32'h70);
    bus(1'b1, OFS_IRQ_ST, 32'h77);
    rnd = lfsr(rnd);
    c = int'(rnd[7:0]) % 3;
    rx_fault[c] <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check_bit(irq, 1'b1);
    check_bit(status[c].fault, 1'b1);
    @(posedge clk);
    expect_read(OFS_IRQ_ST, 32'h10 << c, 32'h77, 2'b00);
    bus(1'b1, OFS_IRQ_MK, 32'h0);
    #1;
    check_bit(irq, 1'b0);
    @(posedge clk);
    bus(1'b1, OFS_IRQ_MK, 32'h70);
    bus(1'b1, OFS_IRQ_ST, 32'h10 << c);
    #1;
    check_bit(irq, 1'b0);
    @(posedge clk);
    rx_fault <= '0;
    repeat (6) @(posedge clk);
    expect_read(OFS_STATUS, 32'h0, 32'h70, 2'b00);
    bus(1'b1, OFS_CLEAR, 32'h1);
    expect_read(OFS_POS0, 32'h0, ALL, 2'b00);
    repeat (3) @(posedge clk);
    check_word(32'(notes.size()), 32'h0, ALL);
    test_done();
  end
endmodule : quadrature_position_counter_test
